// ==== core/ir_pins_defines.vh ====
// Constants for the infrared pin routing and host port block
// What this block does
// - Main output: link when remote off, remote when pin-select high, else low
// - Remote output carries remote wave when remote on and pin-select low, else low
// - Passthrough forwards external input to selected output
// - Link interrupt high after reset, low on event
// - Remote interrupt high after reset, independent low
// - Strobes honoured only while chip select low
// - Reset low initialises all internal state except the input synchronisers
// - Power-down low suspends normal operation
// - Aux control and transmit outputs low after reset
`ifndef IR_PINS_DEFINES_VH
`define IR_PINS_DEFINES_VH
`define DATA_W 16
`define ADDR_W 4
`define REG_COUNT 16
`define REG_RESET 16'h0000
`define SYNC_STAGES 2
`endif

// ==== core/pin_sync.v ====
// Two flip-flop synchroniser for a bundle of asynchronous pin inputs
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_value,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_sys) begin
                if (rst) begin
                    meta_q[i] <= reset_value[i];
                    stable_q[i] <= reset_value[i];
                end else begin
                    meta_q[i] <= async_in[i];
                    stable_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    // Both stages restart from the idle levels, so no false strobe shows while they refill
    assign sync_out = stable_q;
endmodule

// ==== core/ir_pin_routing_host_port.v ====
// Pin routing, host register port and interrupt pins of the infrared link controller
`include "ir_pins_defines.vh"
module ir_pin_routing_host_port (
    input wire clk_sys,
    input wire rst,
    input wire reset_n,
    input wire power_down_n,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire [`ADDR_W-1:0] host_addr,
    input wire [`DATA_W-1:0] host_data_in,
    output reg [`DATA_W-1:0] host_data_out,
    output wire host_data_oe_n,
    input wire ir_receive_in,
    input wire external_ir_in,
    input wire link_tx_wave,
    input wire remote_tx_wave,
    input wire remote_select,
    input wire remote_pin_select,
    input wire passthrough_select,
    input wire link_event,
    input wire remote_event,
    output reg ir_transmit_out,
    output reg remote_transmit_out,
    output reg link_irq_n,
    output reg remote_irq_n,
    output reg aux_control_out,
    output wire ir_receive_sync,
    output wire powered_down
);
    localparam NCTRL = 7;
    localparam NBUS = `ADDR_W + `DATA_W;
    // Control pins idle high, so the chains restart from the idle levels
    localparam [NCTRL-1:0] CTRL_IDLE = 7'h7c;
    localparam [1:0] ROUTE_LINK = 2'b00;
    localparam [1:0] ROUTE_MAIN_REMOTE = 2'b01;
    localparam [1:0] ROUTE_REMOTE_PIN = 2'b10;

    wire [NCTRL-1:0] ctrl_s;
    wire [NBUS-1:0] bus_s;

    pin_sync #(
        .WIDTH(NCTRL)
    ) ctrl_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({reset_n, power_down_n, cs_n, rd_n, wr_n, ir_receive_in, external_ir_in}),
        .reset_value(CTRL_IDLE),
        .sync_out(ctrl_s)
    );

    // Address and data pass the same two stages as the strobes, so all of them line up
    pin_sync #(
        .WIDTH(NBUS)
    ) bus_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({host_addr, host_data_in}),
        .reset_value({NBUS{1'b0}}),
        .sync_out(bus_s)
    );

    wire reset_n_s = ctrl_s[6];
    wire power_down_n_n_s = ctrl_s[5];
    wire cs_n_s = ctrl_s[4];
    wire rd_n_s = ctrl_s[3];
    wire wr_n_s = ctrl_s[2];
    wire ext_ir_s = ctrl_s[0];
    wire [`ADDR_W-1:0] addr_s = bus_s[NBUS-1:`DATA_W];
    wire [`DATA_W-1:0] data_s = bus_s[`DATA_W-1:0];
    assign ir_receive_sync = ctrl_s[1];

    wire clear = rst | ~reset_n_s;
    wire active = power_down_n_n_s;
    assign powered_down = ~power_down_n_n_s;

    // A write lands once per low period of the strobe, on its first synchronised cycle
    reg wr_n_prev_q;
    wire rd_sel = ~cs_n_s & ~rd_n_s;
    wire wr_edge = ~cs_n_s & ~wr_n_s & wr_n_prev_q;
    // Writes are ignored in power-down, so the waiting state keeps its settings
    wire wr_strobe = wr_edge & active;
    wire [`REG_COUNT-1:0] wr_onehot = {{(`REG_COUNT-1){1'b0}}, 1'b1} << addr_s;
    wire [`REG_COUNT-1:0] wr_hit;
    genvar j;
    generate
        for (j = 0; j < `REG_COUNT; j = j + 1) begin : g_slot
            assign wr_hit[j] = wr_strobe & wr_onehot[j];
        end
    endgenerate

    // Resets high like the idle strobe, so leaving reset gives no false write edge
    always @(posedge clk_sys) begin
        if (clear) begin
            wr_n_prev_q <= 1'b1;
        end else begin
            wr_n_prev_q <= wr_n_s;
        end
    end

    reg [`DATA_W-1:0] regs_q [0:`REG_COUNT-1];
    integer k;
    always @(posedge clk_sys) begin
        for (k = 0; k < `REG_COUNT; k = k + 1) begin
            if (clear) begin
                regs_q[k] <= `REG_RESET;
            end else if (wr_hit[k]) begin
                regs_q[k] <= data_s;
            end
        end
    end

    // Read data is caught while the read is selected and then held for the host
    // The bus stays driven two clocks past the strobes; that is the synchroniser's price
    wire [`DATA_W-1:0] read_word = regs_q[addr_s];
    always @(posedge clk_sys) begin
        if (clear) begin
            host_data_out <= `REG_RESET;
        end else if (rd_sel) begin
            host_data_out <= read_word;
        end
    end
    assign host_data_oe_n = ~rd_sel | clear;

    // Routing follows the selects directly; they come from logic on this clock
    reg [1:0] route_sel;
    always @* begin
        if (!remote_select) begin
            route_sel = ROUTE_LINK;
        end else if (remote_pin_select) begin
            route_sel = ROUTE_MAIN_REMOTE;
        end else begin
            route_sel = ROUTE_REMOTE_PIN;
        end
    end
    // Passthrough takes the synchronised pin, so it trails the external input by two clocks
    wire link_src = passthrough_select ? ext_ir_s : link_tx_wave;
    wire remote_src = passthrough_select ? ext_ir_s : remote_tx_wave;

    reg main_tx_d;
    reg remote_tx_d;
    reg link_irq_d;
    reg remote_irq_d;
    reg aux_d;

    always @* begin
        main_tx_d = 1'b0;
        remote_tx_d = 1'b0;
        case (route_sel)
            ROUTE_LINK: begin
                main_tx_d = link_src;
            end
            ROUTE_MAIN_REMOTE: begin
                main_tx_d = remote_src;
            end
            ROUTE_REMOTE_PIN: begin
                remote_tx_d = remote_src;
            end
            default: begin
                main_tx_d = 1'b0;
                remote_tx_d = 1'b0;
            end
        endcase
        // Transmit paths are forced low while suspended
        if (!active) begin
            main_tx_d = 1'b0;
            remote_tx_d = 1'b0;
        end
    end

    // Interrupt pins follow the event levels and rest high while suspended
    always @* begin
        link_irq_d = 1'b1;
        remote_irq_d = 1'b1;
        if (active) begin
            link_irq_d = ~link_event;
            remote_irq_d = ~remote_event;
        end
    end

    // Aux control mirrors bit 0 of register 0 and freezes while suspended
    always @* begin
        aux_d = aux_control_out;
        if (active) begin
            aux_d = regs_q[0][0];
        end
    end

    // Transmit, interrupt and aux pins leave from flip-flops, so no decode glitch reaches the transceiver
    always @(posedge clk_sys) begin
        if (clear) begin
            ir_transmit_out <= 1'b0;
            remote_transmit_out <= 1'b0;
        end else begin
            ir_transmit_out <= main_tx_d;
            remote_transmit_out <= remote_tx_d;
        end
    end

    always @(posedge clk_sys) begin
        if (clear) begin
            link_irq_n <= 1'b1;
            remote_irq_n <= 1'b1;
        end else begin
            link_irq_n <= link_irq_d;
            remote_irq_n <= remote_irq_d;
        end
    end

    always @(posedge clk_sys) begin
        if (clear) begin
            aux_control_out <= 1'b0;
        end else begin
            aux_control_out <= aux_d;
        end
    end

    // Oscillator settling after power-down is left to the host, which holds reset_n low
    // long enough; the block only ever sees the synchronised reset
endmodule

// ==== sim/ir_transceiver_model.sv ====
// Loopback model of the infrared transceiver module
module ir_transceiver_model (
    input wire clk_sys,
    input wire ir_transmit_out,
    output logic ir_receive_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Emitter light reaches the receiver a cycle later, like an optical echo
    always @(posedge clk_sys) ir_receive_in <= ir_transmit_out;
endmodule

// ==== sim/ir_pins_checker_properties.sv ====
// Concurrent checks on the pins of the routing and host port block
module ir_pins_checker (
    input wire clk_sys,
    input wire rst,
    input wire cs_n,
    input wire rd_n,
    input wire host_data_oe_n,
    input wire link_tx_wave,
    input wire remote_tx_wave,
    input wire remote_select,
    input wire remote_pin_select,
    input wire passthrough_select,
    input wire external_ir_in,
    input wire link_event,
    input wire remote_event,
    input wire ir_transmit_out,
    input wire remote_transmit_out,
    input wire link_irq_n,
    input wire remote_irq_n,
    input wire aux_control_out,
    input wire powered_down
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire run = !powered_down && !passthrough_select;
    sequence read_held;
        (!cs_n && !rd_n) [*3];
    endsequence
    a_main_link: assert property (run && !remote_select |=>
        ir_transmit_out == $past(link_tx_wave)) else $error("main not link");
    a_main_remote: assert property (run && remote_select && remote_pin_select |=>
        ir_transmit_out == $past(remote_tx_wave)) else $error("main not remote");
    a_remote_pin: assert property (run && remote_select && !remote_pin_select |=>
        remote_transmit_out == $past(remote_tx_wave)) else $error("remote pin wrong");
    a_pass_main: assert property (passthrough_select && !remote_select && !powered_down
        |=> ir_transmit_out == $past(external_ir_in, 3)) else $error("pass wrong");
    a_link_irq: assert property (!powered_down |=> link_irq_n == !$past(link_event))
        else $error("link irq wrong");
    a_remote_irq: assert property (!powered_down |=> remote_irq_n == !$past(remote_event))
        else $error("remote irq wrong");
    a_bus_idle: assert property ((cs_n || rd_n) [*3] |-> host_data_oe_n)
        else $error("bus driven");
    a_bus_read: assert property (read_held |-> !host_data_oe_n)
        else $error("bus not driven");
    a_pd_quiet: assert property (powered_down [*2] |-> !ir_transmit_out && link_irq_n)
        else $error("active in power down");
    a_reset_vals: assert property ($fell(rst) |-> !aux_control_out && !ir_transmit_out
        && !remote_transmit_out && link_irq_n && remote_irq_n) else $error("reset value");
endmodule
bind ir_pin_routing_host_port ir_pins_checker ir_pins_checker_inst (.*);

// ==== sim/ir_pin_routing_host_port_test.sv ====
// Self-checking bench for the pin routing and host port block
module ir_pin_routing_host_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, reset_n = 1, power_down_n = 1, cs_n = 1, rd_n = 1, wr_n = 1;
    logic [3:0] host_addr = 4'h0;
    logic [15:0] host_data_in = 16'h0000;
    logic external_ir_in = 0, link_tx_wave = 0, remote_tx_wave = 0, remote_select = 0;
    logic remote_pin_select = 0, passthrough_select = 0, link_event = 0, remote_event = 0;
    wire [15:0] host_data_out;
    wire host_data_oe_n, ir_receive_in, ir_transmit_out, remote_transmit_out, link_irq_n;
    wire remote_irq_n, aux_control_out, ir_receive_sync, powered_down;
    int n_fail = 0, num_checks = 0, cyc = 0;
    ir_pin_routing_host_port ir_pin_routing_host_port_inst (.*);
    ir_transceiver_model ir_transceiver_model_inst (.*);
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    task results;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Strobes held 4 cycles, longer than the 3-cycle minimum, then 4 idle
    task bus(input logic c, input logic r, input logic w, input logic [15:0] d);
        {cs_n, rd_n, wr_n, host_data_in} = {c, r, w, d};
        step(4);
        chk(host_data_oe_n, c | r);
        {cs_n, rd_n, wr_n} = 3'h7;
        step(4);
    endtask
    task t_route;
        link_tx_wave = 1;
        step(2);
        chk(ir_transmit_out, 1'h1);
        step(3);
        chk(ir_receive_sync, 1'h1);
        {remote_select, remote_pin_select} = 2'h3;
        step(2);
        chk(ir_transmit_out, 1'h0);
        {remote_pin_select, remote_tx_wave, link_tx_wave} = 3'h2;
        step(2);
        chk(remote_transmit_out, 1'h1);
        passthrough_select = 1;
        step(4);
        chk(remote_transmit_out, 1'h0);
        {remote_select, external_ir_in} = 2'h1;
        step(4);
        chk(ir_transmit_out, 1'h1);
        {passthrough_select, external_ir_in} = 2'h0;
    endtask
    task t_irq;
        link_event = 1;
        step(2);
        chk({link_irq_n, remote_irq_n}, 2'h1);
        {link_event, remote_event} = 2'h1;
        step(2);
        chk({link_irq_n, remote_irq_n}, 2'h2);
        remote_event = 0;
    endtask
    task t_bus;
        bus(0, 1, 0, 16'h0001);
        chk(aux_control_out, 1'h1);
        bus(0, 0, 1, 16'h0000);
        chk(host_data_out, 16'h0001);
        bus(1, 1, 0, 16'h0000);
        bus(1, 0, 1, 16'h0000);
        chk(aux_control_out, 1'h1);
    endtask
    task t_power;
        {power_down_n, link_event, link_tx_wave} = 3'h3;
        step(4);
        bus(0, 1, 0, 16'h0000);
        chk({ir_transmit_out, link_irq_n, aux_control_out}, 3'h3);
        chk(powered_down, 1'h1);
        {power_down_n, reset_n, link_event, link_tx_wave} = 4'h8;
        step(6);
        chk(aux_control_out, 1'h0);
        chk(host_data_out, 16'h0000);
        chk(powered_down, 1'h0);
        reset_n = 1;
        step(4);
    endtask
    initial begin
        step(8);
        rst = 0;
        step(3);
        t_route();
        t_irq();
        t_bus();
        t_power();
        results();
    end
endmodule
